// [dv/panel_ctrl_model.sv]
// display controller model: shift words, transfer, count clocks, ramp
`timescale 1ns/1ps
module panel_ctrl_model
  import gray_shade_pkg::*;
(
  input  wire logic            clock_i,
  output logic                 shift_clk_o,
  output logic                 count_clk_o,
  output logic                 load_count_o,
  output logic [NUM_LANES-1:0] lanes_o,
  output logic [RAMP_W-1:0]    ramp_o
);
  logic ramping_q;
  // idle levels; count clock stands low outside frames
  initial begin
    shift_clk_o = 1'b0;
    count_clk_o = 1'b0;
    load_count_o = 1'b0;
    lanes_o = 4'h5;
    ramp_o = 8'h00;
    ramping_q = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // ramp rises one step a clock during a frame, else falls back
  always @(posedge clock_i) begin
    ramp_o <= ramping_q ? ramp_o + 8'h01 : 8'h00;
  end
  // one word per shift fall; lanes invert after hold so no stale data
  task automatic shift_word(input logic [NUM_LANES-1:0] w);
    @(posedge clock_i);
    shift_clk_o <= 1'b1;
    lanes_o <= w;
    @(posedge clock_i);
    shift_clk_o <= 1'b0;
    @(posedge clock_i);
    lanes_o <= ~w;
  endtask
  // transfer pulse; no shift falls can occur while it is high
  task automatic transfer(input int n);
    @(posedge clock_i);
    load_count_o <= 1'b1;
    repeat (n) @(posedge clock_i);
    load_count_o <= 1'b0;
  endtask
  // count clock of four cycles a period, ramp started with the first
  task automatic count_frame(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clock_i);
      count_clk_o <= 1'b1;
      ramping_q <= 1'b1;
      @(posedge clock_i);
      @(posedge clock_i);
      count_clk_o <= 1'b0;
      @(posedge clock_i);
    end
    ramping_q <= 1'b0;
  endtask
endmodule // panel_ctrl_model

// [dv/shade_driver_properties.sv]
// port-level assertions for the gray-shade column driver
`timescale 1ns/1ps
module shade_driver_properties
  import gray_shade_pkg::*;
(
  input wire logic                       clock_i,
  input wire logic                       rst_n_i,
  input wire logic                       count_clk_i,
  input wire logic                       load_count_i,
  input wire logic                       lane0_out_o,
  input wire logic                       lane1_out_o,
  input wire logic                       lane2_out_o,
  input wire logic                       lane3_out_o,
  input wire logic [NUM_COLS*RAMP_W-1:0] column_drive_out_o,
  input wire logic [NUM_COLS-1:0]        pulse_o,
  input wire logic                       counting_o,
  input wire logic                       frame_done_o,
  input wire logic [PERIOD_W-1:0]        period_o
);
  wire logic [3:0] lanes = {lane3_out_o, lane2_out_o,
                            lane1_out_o, lane0_out_o};
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  // a count fall seen while counting, and column 0 resting
  sequence step_s;
    counting_o && !load_count_i && $fell(count_clk_i);
  endsequence
  sequence rest_s;
    !pulse_o[0] [*2] ##0 !load_count_i;
  endsequence
  cols_low_a: assert property (
    load_count_i |=> column_drive_out_o == '0)
    else $error("columns not low during transfer");
  chains_frozen_a: assert property (
    load_count_i |=> $stable(lanes))
    else $error("chains moved during transfer");
  start_all_a: assert property (
    $rose(counting_o) |-> pulse_o == '1)
    else $error("pulses did not all start with counting");
  period_step_a: assert property (
    step_s |=> period_o == $past(period_o) + 1)
    else $error("count fall did not advance one step");
  no_restart_a: assert property (
    counting_o |=> (pulse_o & ~$past(pulse_o)) == '0)
    else $error("pulse rose in mid count");
  done_clear_a: assert property (
    frame_done_o |-> pulse_o == '0)
    else $error("pulse alive after frame end");
  done_stay_a: assert property (
    frame_done_o && !load_count_i |=> frame_done_o)
    else $error("frame end left without transfer");
  done_period_a: assert property (
    $rose(frame_done_o) |-> period_o == COUNT_PERIODS)
    else $error("frame ended at wrong step");
  level_hold_a: assert property (
    rest_s |=> $stable(column_drive_out_o[7:0]))
    else $error("column level moved without pulse");
endmodule // shade_driver_properties

// [dv/testbench.sv]
// self-checking bench for the gray-shade column driver
`timescale 1ns/1ps
module testbench
  import gray_shade_pkg::*;
;
  logic                       clock_i = 1'b0;
  logic                       rst_n_i = 1'b0;
  logic                       shift_clk, count_clk, load_count;
  logic [NUM_LANES-1:0]       lanes;
  logic [RAMP_W-1:0]          ramp, got;
  logic [3:0]                 lane_out;
  logic [NUM_COLS*RAMP_W-1:0] drive;
  logic [NUM_COLS-1:0]        pulse;
  logic                       shift_ready, chain_idle, counting, done;
  logic [PERIOD_W-1:0]        period;
  logic [CODE_W-1:0]          codes [NUM_COLS];
  logic [RAMP_W-1:0]          last_ramp [NUM_COLS];
  int                         width [NUM_COLS];
  int                         errors = 0;
  int                         n_compared = 0;
  int                         cycles = 0;
  int                         seed = 14251;
  always #5 clock_i = ~clock_i;
  gray_shade_column_driver gray_shade_column_driver_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .shift_clk_i(shift_clk),
    .count_clk_i(count_clk), .load_count_i(load_count),
    .lane0_in_i(lanes[0]), .lane1_in_i(lanes[1]), .lane2_in_i(lanes[2]),
    .lane3_in_i(lanes[3]), .ramp_level_in_i(ramp),
    .lane0_out_o(lane_out[0]), .lane1_out_o(lane_out[1]),
    .lane2_out_o(lane_out[2]), .lane3_out_o(lane_out[3]),
    .column_drive_out_o(drive), .pulse_o(pulse),
    .shift_ready_o(shift_ready), .chain_idle_o(chain_idle),
    .counting_o(counting), .frame_done_o(done), .period_o(period));
  panel_ctrl_model panel_ctrl_model_inst (
    .clock_i(clock_i), .shift_clk_o(shift_clk), .count_clk_o(count_clk),
    .load_count_o(load_count), .lanes_o(lanes), .ramp_o(ramp));
  ////////////////////////////////////////////////////////////////
  // shade number of a code, walking the polynomial order
  function automatic int shade_of(input logic [3:0] c);
    logic [3:0] seq [16] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc,
                             4'hb, 4'h5, 4'ha, 4'h7, 4'he, 4'hf, 4'hd, 4'h9};
    for (int s = 0; s < 16; s++) if (seq[s] === c) return s + 1;
    return 0;
  endfunction
  // lane word of a code: lane0 carries the first code bit
  function automatic logic [3:0] word_of(input logic [3:0] c);
    return {c[0], c[1], c[2], c[3]};
  endfunction
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // pulse widths in cycles, ramp at each pulse's last cycle, hang limit
  always @(negedge clock_i) begin
    cycles++;
    for (int c = 0; c < NUM_COLS; c++) begin
      if (pulse[c] === 1'b1) begin
        width[c]++;
        last_ramp[c] = ramp;
      end
    end
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  // frame 0 holds every code once; later frames are random
  initial begin
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(negedge clock_i);
    check("shift ready", 1, shift_ready);
    check("chain idle", 1, chain_idle);
    check("pulses", 0, pulse);
    for (int f = 0; f < 3; f++) begin
      for (int c = 0; c < NUM_COLS; c++)
        codes[c] = (f == 0) ? 4'(c) : 4'($random(seed));
      for (int c = NUM_COLS - 1; c >= 0; c--)
        panel_ctrl_model_inst.shift_word(word_of(codes[c]));
      repeat (3) @(negedge clock_i);
      check("chain idle", 1, chain_idle);
      check("serial out", word_of(codes[15]), lane_out);
      panel_ctrl_model_inst.transfer(3);
      @(negedge clock_i);
      check("columns low", 0, {31'h0, |drive});
      check("pulses idle", 0, pulse);
      for (int c = 0; c < NUM_COLS; c++) width[c] = 0;
      panel_ctrl_model_inst.count_frame(20);
      repeat (2) @(negedge clock_i);
      check("frame done", 1, done);
      check("period", 32'(COUNT_PERIODS), period);
      check("pulses ended", 0, pulse);
      for (int c = 0; c < NUM_COLS; c++) begin
        got = drive[c*RAMP_W +: RAMP_W];
        check("width", 4 * shade_of(codes[c]), width[c]);
        check("level", 1, {31'h0, got + 8'h01 >= last_ramp[c]
              && got <= last_ramp[c] + 8'h01});
      end
    end
    print_verdict();
  end
endmodule // testbench
bind gray_shade_column_driver shade_driver_properties
  shade_driver_properties_inst (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .count_clk_i(count_clk_i),
  .load_count_i(load_count_i), .lane0_out_o(lane0_out_o),
  .lane1_out_o(lane1_out_o), .lane2_out_o(lane2_out_o),
  .lane3_out_o(lane3_out_o), .column_drive_out_o(column_drive_out_o),
  .pulse_o(pulse_o), .counting_o(counting_o),
  .frame_done_o(frame_done_o), .period_o(period_o));

// [verilog/gray_shade_column_driver.sv]
// top level: sixteen-column gray-shade driver logic with cascade chains
`timescale 1ns/1ps
module gray_shade_column_driver
  import gray_shade_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       shift_clk_i,
  input  wire logic                       count_clk_i,
  input  wire logic                       load_count_i,
  input  wire logic                       lane0_in_i,
  input  wire logic                       lane1_in_i,
  input  wire logic                       lane2_in_i,
  input  wire logic                       lane3_in_i,
  input  wire logic [RAMP_W-1:0]          ramp_level_in_i,
  output logic                            lane0_out_o,
  output logic                            lane1_out_o,
  output logic                            lane2_out_o,
  output logic                            lane3_out_o,
  output logic [NUM_COLS*RAMP_W-1:0]      column_drive_out_o,
  output logic [NUM_COLS-1:0]             pulse_o,
  output logic                            shift_ready_o,
  output logic                            chain_idle_o,
  output logic                            counting_o,
  output logic                            frame_done_o,
  output logic [PERIOD_W-1:0]             period_o
);

  // conversion sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_ARMED = 3'b010,
    ST_COUNT = 3'b011,
    ST_DONE  = 3'b100
  } seq_state_t;

  seq_state_t            state_q;
  seq_state_t            state_d;
  logic                  shift_clk_q;
  logic                  count_clk_q;
  logic                  shift_fall;
  logic                  count_fall;
  logic                  push_valid;
  logic [NUM_LANES-1:0]  push_word;
  logic                  pop_valid;
  logic                  pop_ready;
  logic [NUM_LANES-1:0]  pop_word;
  logic                  pop;
  logic [NUM_COLS-1:0]   chain_q [NUM_LANES];
  logic                  start_cnt;
  logic                  step_cnt;
  logic [PERIOD_W-1:0]   period_q;
  logic [NUM_COLS-1:0]   pulse;
  logic [RAMP_W-1:0]     level_q [NUM_COLS];

  ////////////////////////////////////////////////////////////////////////////
  // edge detection on the partner's clocks; they are sampled as plain
  // synchronous levels, so each must stay high and low for a cycle at least

  // previous levels, reset low so a clock held low never looks like a fall
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      shift_clk_q <= 1'b0;
      count_clk_q <= 1'b0;
    end else begin
      shift_clk_q <= shift_clk_i;
      count_clk_q <= count_clk_i;
    end
  end

  assign shift_fall = shift_clk_q & ~shift_clk_i;
  assign count_fall = count_clk_q & ~count_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // input buffer: one word carries one bit of every lane

  // lane 0 is code bit A, the most significant one
  assign push_word  = {lane3_in_i, lane2_in_i, lane1_in_i, lane0_in_i};
  // shift falls seen during a transfer are dropped
  assign push_valid = shift_fall & ~load_count_i;
  // chains stay frozen while the transfer is high
  assign pop_ready  = ~load_count_i;
  assign pop        = pop_valid & pop_ready;

  lane_word_fifo #(
    .W     (NUM_LANES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (shift_ready_o),
    .in_data_i   (push_word),
    .out_valid_o (pop_valid),
    .out_ready_i (pop_ready),
    .out_data_o  (pop_word)
  );

  // the partner must not raise the transfer before the buffer has drained
  assign chain_idle_o = ~pop_valid;

  ////////////////////////////////////////////////////////////////////////////
  // shift chains: one per lane, sixteen stages each

  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
    // a new bit enters stage 0, the oldest falls out of the last stage
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        chain_q[l] <= CHAIN_RESET;
      end else if (pop) begin
        chain_q[l] <= {chain_q[l][NUM_COLS-2:0], pop_word[l]};
      end
    end
  end

  // delayed data for the next chip in the cascade
  assign lane0_out_o = chain_q[0][NUM_COLS-1];
  assign lane1_out_o = chain_q[1][NUM_COLS-1];
  assign lane2_out_o = chain_q[2][NUM_COLS-1];
  assign lane3_out_o = chain_q[3][NUM_COLS-1];

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (load_count_i) begin
          state_d = ST_LOAD;
        end
      end
      ST_LOAD: begin
        if (!load_count_i) begin
          state_d = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (load_count_i) begin
          state_d = ST_LOAD;
        end else if (count_fall) begin
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (load_count_i) begin
          state_d = ST_LOAD;
        end else if (count_fall && period_q == COUNT_PERIODS - 1'b1) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (load_count_i) begin
          state_d = ST_LOAD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // first fall opens every pulse, later falls step the counters
  assign start_cnt = (state_q == ST_ARMED) & count_fall & ~load_count_i;
  assign step_cnt  = (state_q == ST_COUNT) & count_fall & ~load_count_i;

  // count periods since the start, so a frame ends even if the ramp
  // keeps clocking; falls after the end are ignored until the next transfer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      period_q <= PERIOD_RESET;
    end else if (load_count_i) begin
      period_q <= PERIOD_RESET;
    end else if (step_cnt) begin
      period_q <= period_q + 1'b1;
    end
  end

  assign counting_o   = (state_q == ST_COUNT);
  assign frame_done_o = (state_q == ST_DONE);
  assign period_o     = period_q;

  ////////////////////////////////////////////////////////////////////////////
  // per column: counter plus sample-and-hold of the ramp level

  for (genvar c = 0; c < NUM_COLS; c++) begin : g_col
    logic [CODE_W-1:0] code;

    // bit A from lane 0 down to bit D from lane 3
    assign code = {chain_q[0][c], chain_q[1][c],
                   chain_q[2][c], chain_q[3][c]};

    shade_counter u_counter (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .load_i  (load_count_i),
      .code_i  (code),
      .start_i (start_cnt),
      .step_i  (step_cnt),
      .pulse_o (pulse[c])
    );

    // follow the ramp while the pulse is high, hold afterwards; the
    // transfer forces the column low so old levels never leak into a frame
    always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
        level_q[c] <= LEVEL_RESET;
      end else if (load_count_i) begin
        level_q[c] <= LEVEL_RESET;
      end else if (pulse[c]) begin
        level_q[c] <= ramp_level_in_i;
      end
    end

    assign column_drive_out_o[c*RAMP_W +: RAMP_W] = level_q[c];
  end

  assign pulse_o = pulse;

endmodule // gray_shade_column_driver

// [verilog/gray_shade_pkg.sv]
// constants and types shared by the gray-shade column driver design
//
// Overview of operation
// - each of sixteen columns keeps a 4-bit shade code in shift storage.
// - four serial inputs feed four chains, one code bit per column each.
// - each chain's last stage drives a serial output for cascading chips.
// - transfer high: codes copied, chains frozen, columns low, no shifts.
// - transfer low releases chains from counters and lets counters count.
// - counting starts on first count-clock fall, advances on later falls.
// - each channel pulse starts with counting and ends as its code sets.
// - a channel follows the ramp during its pulse, then holds the level.
// - each code selects one of sixteen distinct pulse lengths.
// - sixteen independent counters, each loaded from its own column bits.
// - counters step a linear feedback sequence, not binary order.
// - ABCD 0000,0001,0010,0100,1000,0011,0110,1100 are shades 1 to 8.
// - codes 1011,0101,1010,0111,1110,1111,1101,1001 are shades 9 to 16.
// - serial data shifts in on shift-clock falls while transfer is low.
package gray_shade_pkg;

  // geometry
  localparam int NUM_COLS   = 16;
  localparam int NUM_LANES  = 4;
  localparam int CODE_W     = 4;
  localparam int RAMP_W     = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int PERIOD_W   = 5;

  // shade code sequence: shade 1 is the lock-up code, shade 2 ends the walk
  localparam logic [CODE_W-1:0] CODE_DIMMEST   = 4'h0;
  localparam logic [CODE_W-1:0] CODE_LAST_STEP = 4'h1;
  localparam logic [CODE_W-1:0] LFSR_TAPS      = 4'h3;

  // count periods in one conversion, matching the ramp rise
  localparam logic [PERIOD_W-1:0] COUNT_PERIODS = 5'h10;

  // values after reset
  localparam logic [CODE_W-1:0]   CODE_RESET   = 4'h0;
  localparam logic [RAMP_W-1:0]   LEVEL_RESET  = 8'h00;
  localparam logic [PERIOD_W-1:0] PERIOD_RESET = 5'h00;
  localparam logic [NUM_COLS-1:0] CHAIN_RESET  = 16'h0000;

endpackage

// [verilog/lane_word_fifo.sv]
// small first-in first-out buffer between the serial pins and the chains
`timescale 1ns/1ps
module lane_word_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         full;
  logic         empty;

  ////////////////////////////////////////////////////////////////////////////
  // status: pointers carry one extra wrap bit so full and empty differ
  assign empty       = (wr_q == rd_q);
  assign full        = (wr_q[AW] != rd_q[AW]) &&
                       (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign in_ready_o  = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o  = mem_q[rd_q[AW-1:0]];

  ////////////////////////////////////////////////////////////////////////////
  // storage needs no reset, only the pointers decide what is valid
  always_ff @(posedge clock_i) begin
    if (in_valid_i && !full) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end

  // write pointer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
    end else if (in_valid_i && !full) begin
      wr_q <= wr_q + 1'b1;
    end
  end

  // read pointer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_q <= '0;
    end else if (out_ready_i && !empty) begin
      rd_q <= rd_q + 1'b1;
    end
  end

endmodule // lane_word_fifo

// [verilog/shade_counter.sv]
// one column's polynomial counter turning a shade code into a pulse width
`timescale 1ns/1ps
module shade_counter
  import gray_shade_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  input  wire logic              load_i,
  input  wire logic [CODE_W-1:0] code_i,
  input  wire logic              start_i,
  input  wire logic              step_i,
  output logic                   pulse_o
);

  logic [CODE_W-1:0] state_q;
  logic              active_q;

  // walk the feedback sequence backwards toward the last-step code, so the
  // codes late in the forward sequence give the longest pulses
  function automatic logic [CODE_W-1:0] lfsr_prev(
    input logic [CODE_W-1:0] t
  );
    logic [CODE_W-1:0] u;
    u = t ^ ({CODE_W{t[0]}} & LFSR_TAPS);
    lfsr_prev = {t[0], u[CODE_W-1:1]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // counter state: loaded during transfer, stepped on each later count fall while its pulse is on
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_q <= CODE_RESET;
    end else if (load_i) begin
      state_q <= code_i;
    end else if (step_i && active_q) begin
      if (state_q == CODE_LAST_STEP) begin
        state_q <= CODE_DIMMEST;
      end else if (state_q != CODE_DIMMEST) begin
        state_q <= lfsr_prev(state_q);
      end
    end
  end

  // pulse: on at the first fall, off at the first step fall that finds the lock-up code
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      active_q <= 1'b0;
    end else if (load_i) begin
      active_q <= 1'b0;
    end else if (start_i) begin
      active_q <= 1'b1;
    end else if (step_i && state_q == CODE_DIMMEST) begin
      active_q <= 1'b0;
    end
  end

  assign pulse_o = active_q;

endmodule // shade_counter
